// ### nicm_pkg.sv
package nicm_pkg;
  // Function
  // - Forced mode accepts accesses without configuration
  // - Forced mode: I/O 200h, master on, memory/ROM off
  // - One media path muxed to the MAC
  // - 10 Mbps path: Manchester coding, clock recovery
  // - 100BASE-X path: 4B/5B, scrambling, free-running symbol timing
  // - 4-bit MII paths only when MII selected
  // - Negotiated link switches mux to that function
  // - Boot ROM mapped per ROM control register
  // - ROM memory reads: byte, word, dword
  // - ROM byte access via I/O address/data registers
  // - Two EEPROM words load configuration register
  // - Configuration register resets to 00000010h
  // - Bits 7:6 give boot ROM size
  // - Bit 8 clear checks delimiter JK in 100BASE-TX, counts failures
  // - Bit 14 enables oversize transmit, resets zero
  // - Bit 15 enables oversize receive, resets zero
  // - Bits 23:20 select the transceiver

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [2:0] NICM_ICFG_WIN = 3'h3;
  localparam logic [7:0] NICM_ICFG_OFS = 8'h00;
  localparam logic [2:0] NICM_ROMIO_WIN = 3'h0;
  localparam logic [7:0] NICM_ROM_ADDR_OFS = 8'h04;
  localparam logic [7:0] NICM_ROM_DATA_OFS = 8'h08;
  localparam logic [2:0] NICM_STAT_WIN = 3'h4;
  localparam logic [7:0] NICM_BAD_DELIM_OFS = 8'h0C;
  localparam logic [31:0] NICM_ICFG_RESET = 32'h0000_0010;
  localparam logic [31:0] NICM_ICFG_MASK = 32'h03F0_C1C0;
  localparam int NICM_ROM_SIZE_LSB = 6;
  localparam int NICM_DELIM_DIS_BIT = 8;
  localparam int NICM_TX_LARGE_BIT = 14;
  localparam int NICM_RX_LARGE_BIT = 15;
  localparam int NICM_XCVR_LSB = 20;
  localparam logic [1:0] NICM_ROM_64K = 2'h0;
  localparam logic [1:0] NICM_ROM_128K = 2'h1;
  localparam logic [15:0] NICM_FORCED_IO_BASE = 16'h0200;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int NICM_CLK_NS = 10;
  localparam int NICM_SYM_NS = 40;
  localparam int NICM_BIT10_NS = 100;
  localparam int NICM_SYM_CYC = NICM_SYM_NS / NICM_CLK_NS;
  localparam int NICM_HALF_CYC = NICM_BIT10_NS / (2 * NICM_CLK_NS);
  localparam int NICM_MID_CYC =
    (3 * NICM_BIT10_NS + 4 * NICM_CLK_NS - 1) / (4 * NICM_CLK_NS);

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [4:0] NICM_SYM_IDLE = 5'h1F;
  localparam logic [4:0] NICM_SYM_J = 5'h18;
  localparam logic [4:0] NICM_SYM_K = 5'h11;

  typedef enum logic [3:0] {
    NICM_X_10T = 4'b0000, NICM_X_AUI = 4'b0001, NICM_X_COAX = 4'b0011,
    NICM_X_100TX = 4'b0100, NICM_X_100FX = 4'b0101, NICM_X_MII = 4'b0110,
    NICM_X_AUTO = 4'b1000, NICM_X_EXTMAC = 4'b1001
  } nicm_xcvr_t;

  typedef enum logic [1:0] {
    NICM_M_NONE = 2'b00, NICM_M_10 = 2'b01, NICM_M_100 = 2'b10,
    NICM_M_MII = 2'b11
  } nicm_media_t;

  typedef enum logic [1:0] {
    NICM_R_IDLE = 2'b00, NICM_R_STEP = 2'b01, NICM_R_WAIT = 2'b10,
    NICM_R_DONE = 2'b11
  } nicm_rom_st_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] window;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } nicm_reg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } nicm_mem_req_t;

  typedef struct packed {
    logic configured;
    logic [15:0] io_base;
    logic io_en;
    logic mem_en;
    logic master_en;
    logic rom_en;
    logic [15:0] rom_base;
  } nicm_pci_cfg_t;

  typedef struct packed {
    logic accept;
    logic [15:0] io_base;
    logic io_en;
    logic mem_en;
    logic master_en;
    logic rom_en;
  } nicm_decode_t;
endpackage

// ### nicm_line_codec.sv
`timescale 1ns/1ps
module nicm_line_codec (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Selected path and MAC transmit nibble
  input wire nicm_pkg::nicm_media_t mode,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  // Line side
  input wire logic [4:0] sym_rx,
  input wire logic man_rx,
  output logic [4:0] sym_tx,
  output logic man_tx,
  // Recovered data and delimiter check
  output logic tx_take,
  output logic [3:0] rx_nib,
  output logic rx_valid,
  output logic ssd_done,
  output logic ssd_ok
);
  import nicm_pkg::*;

  typedef struct packed {
    logic [1:0] sym_cnt;
    logic [2:0] half_cnt;
    logic [10:0] lfsr_tx;
    logic [10:0] lfsr_rx;
    logic [4:0] sym_tx;
    logic prev_idle;
    logic ssd_pend;
    logic ssd_done;
    logic ssd_ok;
    logic [3:0] rx_nib;
    logic rx_valid;
    logic tx_take;
    logic [3:0] man_sh;
    logic [2:0] man_h;
    logic man_busy;
    logic man_tx;
    logic mrx_prev;
    logic [3:0] mrx_cnt;
    logic [3:0] mrx_sh;
    logic [1:0] mrx_n;
  } nicm_codec_st_t;

  nicm_codec_st_t s_q;
  nicm_codec_st_t s_d;

  // ----------------------------------------
  // Scrambler step, five bits per symbol
  // ----------------------------------------
  function automatic logic [15:0] scr5(input logic [10:0] l);
    logic [10:0] v;
    logic [4:0] ks;
    v = l;
    ks = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      ks[i] = v[10] ^ v[8];
      v = {v[9:0], ks[i]};
    end
    return {ks, v};
  endfunction

  function automatic logic [4:0] enc(input logic [3:0] n);
    logic [4:0] t [16];
    t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    return t[n];
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic sym_en;
    logic half_en;
    logic [15:0] st;
    logic [15:0] sr;
    logic [4:0] d;
    logic [4:0] dn;
    logic hit;
    logic mb;
    sym_en = 1'b0;
    half_en = 1'b0;
    st = 16'h0000;
    sr = 16'h0000;
    d = 5'h00;
    dn = 5'h00;
    hit = 1'b0;
    mb = 1'b0;
    s_d = s_q;
    s_d.ssd_done = 1'b0;
    s_d.rx_valid = 1'b0;
    s_d.tx_take = 1'b0;
    sym_en = (s_q.sym_cnt == 2'(NICM_SYM_CYC - 1));
    s_d.sym_cnt = sym_en ? 2'h0 : s_q.sym_cnt + 2'h1;
    half_en = (s_q.half_cnt == 3'(NICM_HALF_CYC - 1));
    s_d.half_cnt = half_en ? 3'h0 : s_q.half_cnt + 3'h1;
    if (sym_en && mode == NICM_M_100)
    begin
      // 4B/5B encode and scramble transmit
      st = scr5(s_q.lfsr_tx);
      s_d.lfsr_tx = st[10:0];
      s_d.sym_tx = (tx_en ? enc(txd) : NICM_SYM_IDLE) ^ st[15:11];
      s_d.tx_take = tx_en;
      // Descramble and decode receive
      sr = scr5(s_q.lfsr_rx);
      s_d.lfsr_rx = sr[10:0];
      d = sym_rx ^ sr[15:11];
      for (int i = 0; i < 16; i++)
      begin
        if (enc(4'(i)) == d)
        begin
          hit = 1'b1;
          dn = 5'(i);
        end
      end
      s_d.prev_idle = (d == NICM_SYM_IDLE);
      if (s_q.prev_idle && d != NICM_SYM_IDLE)
      begin
        s_d.ssd_pend = 1'b1;
        s_d.ssd_ok = (d == NICM_SYM_J);
      end
      else if (s_q.ssd_pend)
      begin
        s_d.ssd_pend = 1'b0;
        s_d.ssd_done = 1'b1;
        s_d.ssd_ok = s_q.ssd_ok && (d == NICM_SYM_K);
      end
      else if (hit)
      begin
        s_d.rx_nib = dn[3:0];
        s_d.rx_valid = 1'b1;
      end
    end
    if (half_en && mode == NICM_M_10)
    begin
      // Manchester transmit, second half carries the bit
      if (s_q.man_busy)
      begin
        mb = s_q.man_sh[s_q.man_h[2:1]];
        s_d.man_tx = s_q.man_h[0] ? mb : ~mb;
        s_d.man_h = s_q.man_h + 3'h1;
        s_d.man_busy = (s_q.man_h != 3'h7);
      end
      else if (tx_en)
      begin
        s_d.man_sh = txd;
        s_d.man_busy = 1'b1;
        s_d.man_h = 3'h0;
        s_d.tx_take = 1'b1;
      end
      else
        s_d.man_tx = 1'b0;
    end
    // Manchester receive with mid-bit clock recovery
    s_d.mrx_prev = man_rx;
    if (s_q.mrx_cnt != 4'hF)
      s_d.mrx_cnt = s_q.mrx_cnt + 4'h1;
    if (mode == NICM_M_10 && man_rx != s_q.mrx_prev
        && s_q.mrx_cnt >= 4'(NICM_MID_CYC))
    begin
      s_d.mrx_cnt = 4'h0;
      s_d.mrx_sh = {man_rx, s_q.mrx_sh[3:1]};
      s_d.mrx_n = s_q.mrx_n + 2'h1;
      if (s_q.mrx_n == 2'h3)
      begin
        s_d.rx_nib = {man_rx, s_q.mrx_sh[3:1]};
        s_d.rx_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.lfsr_tx <= 11'h7FF;
      s_q.lfsr_rx <= 11'h7FF;
      s_q.sym_tx <= NICM_SYM_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign sym_tx = s_q.sym_tx;
  assign man_tx = s_q.man_tx;
  assign tx_take = s_q.tx_take;
  assign rx_nib = s_q.rx_nib;
  assign rx_valid = s_q.rx_valid;
  assign ssd_done = s_q.ssd_done;
  assign ssd_ok = s_q.ssd_ok;
endmodule

// ### nicm_config.sv
`timescale 1ns/1ps
module nicm_config #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Mode straps and PCI configuration
  input wire logic forced_config_mode,
  input wire nicm_pkg::nicm_pci_cfg_t pci_cfg,
  output nicm_pkg::nicm_decode_t pci_decode,
  // Register port
  input wire nicm_pkg::nicm_reg_req_t reg_req,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // EEPROM load
  input wire logic ee_valid,
  input wire logic ee_sel,
  input wire logic [15:0] ee_word,
  // Memory-space ROM access
  input wire nicm_pkg::nicm_mem_req_t mem_req,
  output logic mem_ack,
  output logic mem_refused,
  output logic [31:0] mem_rdata,
  // ROM device
  input wire logic [7:0] rom_rdata,
  output logic [16:0] rom_addr,
  output logic [7:0] rom_wdata,
  output logic rom_we,
  output logic rom_oe,
  // Auto-negotiation and statistics
  input wire logic an_link_up,
  input wire logic an_speed100,
  input wire logic stats_enable,
  // MAC side
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  output logic mac_tx_take,
  output logic [3:0] mac_rxd,
  output logic mac_rx_dv,
  output nicm_pkg::nicm_media_t active_media,
  output logic oversize_tx_en,
  output logic oversize_rx_en,
  // Line side
  input wire logic [4:0] sym_rx,
  input wire logic man_rx,
  output logic [4:0] sym_tx,
  output logic man_tx,
  // MII data
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_dv,
  output logic [3:0] mii_txd,
  output logic mii_tx_en
);
  import nicm_pkg::*;

  typedef struct packed {
    logic [31:0] icfg;
    logic [1:0] ee_got;
    logic [16:0] rom_io_addr;
    logic [7:0] rom_io_data;
    logic [31:0] rdata;
    logic ack;
    nicm_decode_t dec;
    nicm_media_t media;
    logic [3:0] mac_rxd;
    logic mac_rx_dv;
    logic mac_take;
    logic [3:0] mii_txd;
    logic mii_tx_en;
    nicm_rom_st_t rst_st;
    logic [1:0] idx;
    logic from_io;
    logic is_wr;
    logic [3:0] be;
    logic [31:0] buf_w;
    logic [16:0] base;
    logic [16:0] rom_addr;
    logic [7:0] rom_wdata;
    logic rom_we;
    logic rom_oe;
    logic mem_ack;
    logic mem_refused;
    logic [31:0] mem_rdata;
    logic [CNT_W-1:0] bad_cnt;
  } nicm_state_t;

  nicm_state_t s_q;
  nicm_state_t s_d;

  logic [4:0] c_sym_tx;
  logic c_man_tx;
  logic c_take;
  logic [3:0] c_rx_nib;
  logic c_rx_valid;
  logic c_ssd_done;
  logic c_ssd_ok;

  // ----------------------------------------
  // Line coding paths
  // ----------------------------------------
  nicm_line_codec u_codec (
    .sys_clk(sys_clk),
    .rst(rst),
    .mode(s_q.media),
    .tx_en(mac_tx_en),
    .txd(mac_txd),
    .sym_rx(sym_rx),
    .man_rx(man_rx),
    .sym_tx(c_sym_tx),
    .man_tx(c_man_tx),
    .tx_take(c_take),
    .rx_nib(c_rx_nib),
    .rx_valid(c_rx_valid),
    .ssd_done(c_ssd_done),
    .ssd_ok(c_ssd_ok)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [31:0] wmask;
    logic [31:0] bemask;
    logic reg_take;
    logic mem_take;
    logic mem_hit;
    logic io_rom;
    logic is_100tx;
    nicm_xcvr_t xsel;
    logic [1:0] rsize;
    wmask = 32'h0000_0000;
    bemask = 32'h0000_0000;
    reg_take = 1'b0;
    mem_take = 1'b0;
    mem_hit = 1'b0;
    io_rom = 1'b0;
    is_100tx = 1'b0;
    xsel = nicm_xcvr_t'(s_q.icfg[NICM_XCVR_LSB +: 4]);
    rsize = s_q.icfg[NICM_ROM_SIZE_LSB +: 2];
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.mem_ack = 1'b0;
    s_d.mem_refused = 1'b0;
    s_d.rom_we = 1'b0;
    s_d.rom_oe = 1'b0;

    // Forced decode settings override PCI configuration
    if (forced_config_mode)
    begin
      s_d.dec.accept = 1'b1;
      s_d.dec.io_base = NICM_FORCED_IO_BASE;
      s_d.dec.io_en = 1'b1;
      s_d.dec.mem_en = 1'b0;
      s_d.dec.master_en = 1'b1;
      s_d.dec.rom_en = 1'b0;
    end
    else
    begin
      s_d.dec.accept = pci_cfg.configured && (s_q.ee_got == 2'h3);
      s_d.dec.io_base = pci_cfg.io_base;
      s_d.dec.io_en = pci_cfg.io_en;
      s_d.dec.mem_en = pci_cfg.mem_en;
      s_d.dec.master_en = pci_cfg.master_en;
      s_d.dec.rom_en = pci_cfg.rom_en;
    end

    // Each EEPROM word fills the low or high half that ee_sel selects
    if (ee_valid)
    begin
      if (ee_sel)
        s_d.icfg[31:16] = ee_word & NICM_ICFG_MASK[31:16];
      else
        s_d.icfg[15:0] = ee_word & NICM_ICFG_MASK[15:0];
      s_d.ee_got[ee_sel] = 1'b1;
    end

    // ----------------------------------------
    // Media multiplexer
    // ----------------------------------------
    case (xsel)
      NICM_X_10T, NICM_X_AUI, NICM_X_COAX:
        s_d.media = NICM_M_10;
      NICM_X_100TX, NICM_X_100FX:
        s_d.media = NICM_M_100;
      NICM_X_MII, NICM_X_EXTMAC:
        s_d.media = NICM_M_MII;
      NICM_X_AUTO:
        s_d.media = an_link_up ? (an_speed100 ? NICM_M_100 : NICM_M_10)
                               : NICM_M_NONE;
      default:
        s_d.media = NICM_M_NONE;
    endcase
    // At most one path reaches the MAC, none when no media is selected
    case (s_q.media)
      NICM_M_MII:
      begin
        s_d.mac_rxd = mii_rxd;
        s_d.mac_rx_dv = mii_rx_dv;
        s_d.mii_txd = mac_txd;
        s_d.mii_tx_en = mac_tx_en;
        s_d.mac_take = mac_tx_en;
      end
      NICM_M_10, NICM_M_100:
      begin
        s_d.mac_rxd = c_rx_nib;
        s_d.mac_rx_dv = c_rx_valid;
        s_d.mii_txd = 4'h0;
        s_d.mii_tx_en = 1'b0;
        s_d.mac_take = c_take;
      end
      default:
      begin
        s_d.mac_rxd = 4'h0;
        s_d.mac_rx_dv = 1'b0;
        s_d.mii_txd = 4'h0;
        s_d.mii_tx_en = 1'b0;
        s_d.mac_take = 1'b0;
      end
    endcase

    // Delimiter check only in 100BASE-TX operation
    is_100tx = (xsel == NICM_X_100TX)
               || (xsel == NICM_X_AUTO && s_q.media == NICM_M_100);
    if (c_ssd_done && !c_ssd_ok && is_100tx && stats_enable
        && !s_q.icfg[NICM_DELIM_DIS_BIT] && s_q.bad_cnt != '1)
      s_d.bad_cnt = s_q.bad_cnt + 1'b1;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    for (int i = 0; i < 4; i++)
      bemask[i*8 +: 8] = {8{reg_req.be[i]}};
    reg_take = reg_req.valid && !s_q.ack && s_q.rst_st == NICM_R_IDLE;
    if (reg_take)
    begin
      io_rom = s_q.dec.accept && reg_req.window == NICM_ROMIO_WIN
               && reg_req.addr == NICM_ROM_DATA_OFS;
      if (!s_q.dec.accept)
      begin
        s_d.ack = 1'b1;
        s_d.rdata = 32'h0000_0000;
      end
      else if (io_rom)
      begin
        // Byte ROM access through I/O registers
        s_d.rst_st = NICM_R_STEP;
        s_d.from_io = 1'b1;
        s_d.is_wr = reg_req.write;
        s_d.be = 4'h1;
        s_d.idx = 2'h0;
        s_d.base = s_q.rom_io_addr;
        s_d.buf_w = {24'h000000, reg_req.wdata[7:0]};
      end
      else if (reg_req.window == NICM_ICFG_WIN
               && reg_req.addr == NICM_ICFG_OFS)
      begin
        s_d.ack = 1'b1;
        s_d.rdata = s_q.icfg & NICM_ICFG_MASK;
        wmask = bemask & NICM_ICFG_MASK;
        if (reg_req.write)
          s_d.icfg = (s_q.icfg & ~wmask) | (reg_req.wdata & wmask);
      end
      else if (reg_req.window == NICM_ROMIO_WIN
               && reg_req.addr == NICM_ROM_ADDR_OFS)
      begin
        s_d.ack = 1'b1;
        s_d.rdata = {15'h0000, s_q.rom_io_addr};
        if (reg_req.write)
          s_d.rom_io_addr = reg_req.wdata[16:0];
      end
      else if (reg_req.window == NICM_STAT_WIN
               && reg_req.addr == NICM_BAD_DELIM_OFS)
      begin
        s_d.ack = 1'b1;
        s_d.rdata = 32'(s_q.bad_cnt);
      end
      else
      begin
        s_d.ack = 1'b1;
        s_d.rdata = 32'h0000_0000;
      end
    end

    // ----------------------------------------
    // Memory-space ROM window
    // ----------------------------------------
    if (rsize == NICM_ROM_128K)
      mem_hit = mem_req.addr[31:17] == pci_cfg.rom_base[15:1];
    else
      mem_hit = mem_req.addr[31:16] == pci_cfg.rom_base;
    mem_take = mem_req.valid && !s_q.mem_ack && !reg_take
               && s_q.rst_st == NICM_R_IDLE && s_q.dec.rom_en && mem_hit;
    if (mem_take)
    begin
      if (mem_req.write && mem_req.be != 4'hF)
      begin
        // Partial ROM writes are dropped
        s_d.mem_ack = 1'b1;
        s_d.mem_refused = 1'b1;
      end
      else
      begin
        // Any byte lanes served on reads
        s_d.rst_st = NICM_R_STEP;
        s_d.from_io = 1'b0;
        s_d.is_wr = mem_req.write;
        s_d.be = mem_req.be;
        s_d.idx = 2'h0;
        s_d.base = {mem_req.addr[16:2], 2'h0};
        if (rsize == NICM_ROM_64K)
          s_d.base[16] = 1'b0;
        s_d.buf_w = mem_req.wdata;
      end
    end

    // ----------------------------------------
    // ROM byte sequencer
    // ----------------------------------------
    case (s_q.rst_st)
      NICM_R_STEP:
      begin
        if (s_q.be[s_q.idx])
        begin
          s_d.rom_addr = s_q.base + 17'(s_q.idx);
          s_d.rom_wdata = s_q.buf_w[s_q.idx*8 +: 8];
          s_d.rom_we = s_q.is_wr;
          s_d.rom_oe = !s_q.is_wr;
          s_d.rst_st = NICM_R_WAIT;
        end
        else if (s_q.idx == 2'h3)
          s_d.rst_st = NICM_R_DONE;
        else
          s_d.idx = s_q.idx + 2'h1;
      end
      NICM_R_WAIT:
      begin
        if (!s_q.is_wr)
          s_d.buf_w[s_q.idx*8 +: 8] = rom_rdata;
        if (s_q.idx == 2'h3 || s_q.from_io)
          s_d.rst_st = NICM_R_DONE;
        else
        begin
          s_d.idx = s_q.idx + 2'h1;
          s_d.rst_st = NICM_R_STEP;
        end
      end
      NICM_R_DONE:
      begin
        s_d.rst_st = NICM_R_IDLE;
        if (s_q.from_io)
        begin
          s_d.ack = 1'b1;
          s_d.rom_io_data = s_q.buf_w[7:0];
          s_d.rdata = {24'h000000, s_q.buf_w[7:0]};
        end
        else
        begin
          s_d.mem_ack = 1'b1;
          s_d.mem_rdata = s_q.is_wr ? 32'h0000_0000 : s_q.buf_w;
        end
      end
      default:
        s_d.rst_st = s_d.rst_st;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.icfg <= NICM_ICFG_RESET;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pci_decode = s_q.dec;
  assign reg_ack = s_q.ack;
  assign reg_rdata = s_q.rdata;
  assign mem_ack = s_q.mem_ack;
  assign mem_refused = s_q.mem_refused;
  assign mem_rdata = s_q.mem_rdata;
  assign rom_addr = s_q.rom_addr;
  assign rom_wdata = s_q.rom_wdata;
  assign rom_we = s_q.rom_we;
  assign rom_oe = s_q.rom_oe;
  assign mac_tx_take = s_q.mac_take;
  assign mac_rxd = s_q.mac_rxd;
  assign mac_rx_dv = s_q.mac_rx_dv;
  assign active_media = s_q.media;
  assign oversize_tx_en = s_q.icfg[NICM_TX_LARGE_BIT];
  assign oversize_rx_en = s_q.icfg[NICM_RX_LARGE_BIT];
  assign sym_tx = c_sym_tx;
  assign man_tx = c_man_tx;
  assign mii_txd = s_q.mii_txd;
  assign mii_tx_en = s_q.mii_tx_en;
endmodule

// ### nicm_config_chk.sv
`timescale 1ns/1ps
module nicm_config_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic forced_config_mode,
  input wire nicm_pkg::nicm_decode_t pci_decode,
  input wire nicm_pkg::nicm_reg_req_t reg_req,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire nicm_pkg::nicm_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic mem_refused,
  input wire logic rom_oe,
  input wire logic oversize_tx_en,
  input wire logic oversize_rx_en
);
  import nicm_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  a_forced_decode: assert property (
    (forced_config_mode && !rst) [*2] |->
    pci_decode == {1'b1, NICM_FORCED_IO_BASE, 4'b1010})
    else $error("forced decode wrong");
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("register ack too long");
  a_rdata_hold: assert property (
    !reg_ack |-> $stable(reg_rdata))
    else $error("read data moved without ack");
  a_zero_bits: assert property (
    reg_ack && reg_req.window == NICM_ICFG_WIN &&
    reg_req.addr == NICM_ICFG_OFS |-> (reg_rdata & ~NICM_ICFG_MASK) == 0)
    else $error("fixed-zero bit read as one");
  a_refuse_cause: assert property (
    mem_refused |-> mem_ack && mem_req.write && mem_req.be != 4'hF)
    else $error("refusal without partial write");
  a_oe_pulse: assert property (rom_oe |=> !rom_oe)
    else $error("read strobe too long");
  a_mem_rom_en: assert property (mem_ack |-> pci_decode.rom_en)
    else $error("memory access with ROM off");
  a_oversize_rst: assert property (
    $fell(rst) |-> !oversize_tx_en && !oversize_rx_en)
    else $error("oversize bits set after reset");
  c_reg: cover property (reg_ack);
  c_refused: cover property (mem_refused);
  c_mem: cover property (mem_ack && !mem_refused);
endmodule
bind nicm_config nicm_config_chk nicm_config_chk_i (.sys_clk, .rst,
  .forced_config_mode, .pci_decode, .reg_req, .reg_ack, .reg_rdata,
  .mem_req, .mem_ack, .mem_refused, .rom_oe, .oversize_tx_en,
  .oversize_rx_en);

// ### nicm_rom_model.sv
`timescale 1ns/1ps
module nicm_rom_model (
  // Clock
  input wire logic sys_clk,
  // ROM pins
  input wire logic [16:0] rom_addr,
  input wire logic [7:0] rom_wdata,
  input wire logic rom_we,
  input wire logic rom_oe,
  output logic [7:0] rom_rdata
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  // Data stands while the strobe is high, then garbage
  always @(posedge sys_clk)
  begin
    if (rom_we)
      mem[int'(rom_addr)] = rom_wdata;
    last <= rom_rdata;
  end
  always @*
    if (rom_oe)
      rom_rdata = mem.exists(int'(rom_addr)) ? mem[int'(rom_addr)] :
        8'(rom_addr ^ (rom_addr >> 8));
    else
      rom_rdata = ~last;
endmodule

// ### tb_nic_internal_config_media_select.sv
`timescale 1ns/1ps
module tb_nic_internal_config_media_select;
  import nicm_pkg::*;
  logic sys_clk = 0, rst = 1, forced_config_mode = 1, ee_valid = 0;
  logic ee_sel = 0, an_link_up = 0, an_speed100 = 0, mac_tx_en = 0;
  logic [15:0] ee_word = 0;
  nicm_pci_cfg_t pci_cfg = '0;
  nicm_reg_req_t reg_req = '0;
  nicm_mem_req_t mem_req = '0;
  nicm_decode_t pci_decode;
  nicm_media_t active_media;
  logic reg_ack, mem_ack, mem_refused, rom_we, rom_oe, mac_tx_take;
  logic mac_rx_dv, oversize_tx_en, oversize_rx_en, man_tx, mii_tx_en, rf;
  logic [31:0] reg_rdata, mem_rdata, q, w, icfg_m;
  logic [16:0] rom_addr;
  logic [7:0] rom_rdata, rom_wdata, rom_m [int];
  logic [3:0] b, mac_txd = 0, mii_rxd = 0, mac_rxd, mii_txd;
  logic [4:0] sym_rx = 0, sym_tx;
  logic man_rx = 0, mii_rx_dv = 0;
  int failures = 0, cmp_count = 0;
  nicm_config nicm_config_i (.sys_clk, .rst, .forced_config_mode,
    .pci_cfg, .pci_decode, .reg_req, .reg_ack, .reg_rdata, .ee_valid,
    .ee_sel, .ee_word, .mem_req, .mem_ack, .mem_refused, .mem_rdata,
    .rom_rdata, .rom_addr, .rom_wdata, .rom_we, .rom_oe, .an_link_up,
    .an_speed100, .stats_enable(1'b1), .mac_tx_en, .mac_txd, .mac_tx_take,
    .mac_rxd, .mac_rx_dv, .active_media, .oversize_tx_en, .oversize_rx_en,
    .sym_rx, .man_rx, .sym_tx, .man_tx, .mii_rxd, .mii_rx_dv, .mii_txd,
    .mii_tx_en);
  nicm_rom_model nicm_rom_model_i (.sys_clk, .rom_addr, .rom_wdata,
    .rom_we, .rom_oe, .rom_rdata);
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    {mac_txd, sym_rx, man_rx, mii_rxd, mii_rx_dv} <= 15'($urandom);
  // ----
  // Tasks and model
  // ----
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("mismatches %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task rw(input logic wr, input logic [2:0] win, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk) reg_req <= '{1'b1, wr, win, a, be, d};
    do @(posedge sys_clk); while (reg_ack !== 1'b1 && ++n < 20);
    if (reg_ack !== 1'b1) failures++;
    q = reg_rdata;
    reg_req.valid <= 1'b0;
  endtask
  task mw(input logic wr, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk) mem_req <= '{1'b1, wr, a, be, d};
    do @(posedge sys_clk); while (mem_ack !== 1'b1 && ++n < 40);
    if (mem_ack !== 1'b1) failures++;
    q = mem_rdata;
    rf = mem_refused;
    mem_req.valid <= 1'b0;
  endtask
  function automatic logic [7:0] rb(int a);
    return rom_m.exists(a) ? rom_m[a] : 8'(a ^ (a >> 8));
  endfunction
  function automatic logic [1:0] med(int c, int l);
    case (c)
      0, 1, 3: return 2'b01;
      4, 5: return 2'b10;
      6, 9: return 2'b11;
      8: return l[1] ? (l[0] ? 2'b10 : 2'b01) : 2'b00;
      default: return 2'b00;
    endcase
  endfunction
  task rd(input logic [31:0] a, input logic [3:0] be);
    logic [31:0] e, m;
    e = 0;
    m = 0;
    for (int i = 0; i < 4; i++)
      if (be[i])
      begin
        m[8*i +: 8] = 8'hFF;
        e[8*i +: 8] = rb({a[16:2], 2'b00} + i);
      end
    mw(0, a, be, 0);
    chk(q & m, e);
  endtask
  task ee(input logic s, input logic [15:0] d);
    @(posedge sys_clk) {ee_valid, ee_sel, ee_word} <= {1'b1, s, d};
    @(posedge sys_clk) ee_valid <= 1'b0;
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    q = $urandom(32'h0739);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rw(0, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'hF, 0);
    chk(q, 0);
    chk(32'(pci_decode), 32'({1'b1, 16'h0200, 4'b1010}));
    w = $urandom;
    ee(0, w[15:0]);
    ee(1, w[31:16]);
    icfg_m = w & NICM_ICFG_MASK;
    rw(0, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'hF, 0);
    chk(q, icfg_m);
    repeat (8)
    begin
      w = $urandom;
      b = 4'($urandom);
      rw(1, NICM_ICFG_WIN, NICM_ICFG_OFS, b, w);
      for (int i = 0; i < 4; i++)
        if (b[i])
          icfg_m[8*i +: 8] = w[8*i +: 8] & NICM_ICFG_MASK[8*i +: 8];
      rw(0, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'hF, 0);
      chk(q, icfg_m);
      chk(32'({oversize_rx_en, oversize_tx_en}),
        32'(icfg_m[15:14]));
    end
    for (int c = 0; c < 16; c++)
      for (int l = 0; l < 4; l++)
      begin
        {an_link_up, an_speed100} <= 2'(l);
        rw(1, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'h4, 32'(c) << NICM_XCVR_LSB);
        repeat (2) @(posedge sys_clk);
        chk(32'(active_media), 32'(med(c, l)));
      end
    forced_config_mode <= 1'b0;
    pci_cfg <= '{1'b1, 16'h0300, 1'b1, 1'b1, 1'b1, 1'b1, 16'h000C};
    rw(1, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'h1, 0);
    rd(32'h000C_0101, 4'h2);
    rd(32'h000C_0102, 4'hC);
    rd(32'h000C_0104, 4'hF);
    w = $urandom;
    mw(1, 32'h000C_0200, 4'h3, w);
    chk(32'(rf), 1);
    rd(32'h000C_0200, 4'hF);
    mw(1, 32'h000C_0200, 4'hF, w);
    chk(32'(rf), 0);
    for (int i = 0; i < 4; i++)
      rom_m[32'h200 + i] = w[8*i +: 8];
    rd(32'h000C_0200, 4'hF);
    rw(1, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'h1, 32'h40);
    rd(32'h000D_0010, 4'hF);
    rw(1, NICM_ROMIO_WIN, NICM_ROM_ADDR_OFS, 4'hF, 32'h123);
    rw(0, NICM_ROMIO_WIN, NICM_ROM_DATA_OFS, 4'hF, 0);
    chk(q & 32'hFF, 32'(rb(32'h123)));
    w = $urandom;
    rw(1, NICM_ROMIO_WIN, NICM_ROM_DATA_OFS, 4'h1, w);
    rw(0, NICM_ROMIO_WIN, NICM_ROM_DATA_OFS, 4'hF, 0);
    chk(q & 32'hFF, 32'(w[7:0]));
    rw(0, 3'h6, 8'h10, 4'hF, 0);
    chk(q, 0);
    pci_cfg.configured <= 1'b0;
    rw(0, NICM_ICFG_WIN, NICM_ICFG_OFS, 4'hF, 0);
    chk(q, 0);
    close_out;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    close_out;
  end
endmodule
